//--- fes_pkg.sv
/*
 package for the flash fault status block: register offset, bit layout,
 reset value, event group struct and timing constants.
 assumes nothing of its surroundings.
*/
package fes_pkg;
   localparam int FES_ADDR_W = 4;
   localparam logic [3:0] FES_CTRL_STAT_OFF = 4'h0;
   localparam int FES_FAULT_BIT = 4;
   localparam int FES_COPY_BIT = 0;
   localparam logic [7:0] FES_CTRL_STAT_RESET = 8'h80;
   localparam logic [7:0] FES_FIXED_ONES = 8'h80;
   localparam logic [31:0] FES_UNMAPPED_DATA = 32'h0000_0000;
   localparam int FES_CLK_MHZ = 200;
   localparam int FES_HOLD_US = 100;
   localparam int FES_HOLD_CYC = FES_HOLD_US * FES_CLK_MHZ;

   typedef struct packed {
      logic irq_taken;
      logic array_read;
      logic sleep_entry;
   } fes_events_t;
endpackage

//--- fes_top.sv
/*
 flash fault status register behind an Avalon-MM slave.
 holds the sticky fault flag, the fixed reserved bits and the
 write-only copy request bit of the control and status byte.
 assumes events and op_active_i arrive from logic on clk_i, so they
 pass no synchroniser; reset_n_i is the power-on reset and the only
 clear of the fault flag; the reset controller keeps it low long
 enough after a fault, this block does not check that.
*/
`timescale 1ns/100ps
module fes_top
   import fes_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // avalon-mm slave
   input wire logic [FES_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // flash sequencer side
   input wire logic op_active_i,
   input wire fes_events_t events_i,
   output logic flash_fault_flag_o,
   output logic prog_erase_allow_o,
   output logic program_copy_request_o
);
   // bus handshake phases
   typedef enum {
      BUS_IDLE,
      BUS_ANSWER
   } fes_bus_state_t;

   // fault flag state
   logic fault_reg;
   logic fault_next;
   logic event_seen;
   logic fault_event;

   // bus handshake state
   fes_bus_state_t bus_state_reg;
   fes_bus_state_t bus_state_next;
   logic request;
   logic hit;
   logic byte_ok;
   logic reg_access;
   logic read_capture;
   logic write_commit;

   // read data path
   logic [7:0] reg_byte;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // copy request pulse
   logic copy_reg;
   logic copy_next;

   // any of the disturbing events in this cycle
   assign event_seen = events_i.irq_taken
      || events_i.array_read
      || events_i.sleep_entry;

   // events only count while an operation runs
   assign fault_event = op_active_i && event_seen;

   // sticky fault flag, no software clear
   always_comb begin
      fault_next = fault_reg;
      if (fault_event) begin
         fault_next = 1'b1;
      end
   end

   // power-on reset is the only clear of the flag
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_reg <= FES_CTRL_STAT_RESET[FES_FAULT_BIT];
      end else begin
         fault_reg <= fault_next;
      end
   end

   // address and lane decode
   assign request = avs_read_i || avs_write_i;
   assign hit = (avs_address_i == FES_CTRL_STAT_OFF);
   assign byte_ok = (avs_byteenable_i == 4'h1);
   assign reg_access = hit && byte_ok;

   // read data is fetched in the first cycle of a request
   assign read_capture = avs_read_i && (bus_state_reg == BUS_IDLE);

   // a write lands at the edge where waitrequest is low
   assign write_commit = avs_write_i && (bus_state_reg == BUS_ANSWER);

   // one wait state for every access
   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         BUS_IDLE: begin
            if (request) begin
               bus_state_next = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            bus_state_next = BUS_IDLE;
         end
         default: begin
            bus_state_next = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_state_reg <= BUS_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   // register byte, one bit at a time
   for (genvar b = 0; b < 8; b++) begin : g_bit
      if (b == FES_FAULT_BIT) begin : g_fault
         assign reg_byte[b] = fault_reg;
      end else if (b == FES_COPY_BIT) begin : g_copy
         // write-only bit, never read back
         assign reg_byte[b] = 1'b0;
      end else begin : g_fixed
         // reserved bits, no write reaches them
         assign reg_byte[b] = FES_FIXED_ONES[b];
      end
   end

   // read data holds until the next read
   always_comb begin
      rdata_next = rdata_reg;
      if (read_capture) begin
         rdata_next = FES_UNMAPPED_DATA;
         if (reg_access) begin
            rdata_next = {24'h00_0000, reg_byte};
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // only bit 0 is writable, as a one-cycle pulse
   always_comb begin
      copy_next = 1'b0;
      if (write_commit && reg_access && !fault_reg) begin
         copy_next = avs_writedata_i[FES_COPY_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         copy_reg <= 1'b0;
      end else begin
         copy_reg <= copy_next;
      end
   end

   // waitrequest drops in the second cycle of a request
   assign avs_waitrequest_o = request && (bus_state_reg != BUS_ANSWER);

   // bus read data
   assign avs_readdata_o = rdata_reg;

   // fault flag and error protection
   assign flash_fault_flag_o = fault_reg;
   assign prog_erase_allow_o = !fault_reg;

   // copy request towards the sequencer
   assign program_copy_request_o = copy_reg;
endmodule

//--- fes_properties.sv
/* fault status port checker; bound to fes_top from the bench */
`timescale 1ns/100ps
module fes_properties import fes_pkg::*; (input wire logic clk_i, reset_n_i,
   avs_read_i, avs_write_i, avs_waitrequest_o, op_active_i, flash_fault_flag_o,
   prog_erase_allow_o, program_copy_request_o,
   input wire fes_events_t events_i, input wire logic [31:0] avs_readdata_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   wire f = flash_fault_flag_o, ev = op_active_i && |events_i;
   wire w = avs_waitrequest_o, c = program_copy_request_o;
   chk_flag_set: assert property (ev |=> f) else $error("set");
   chk_flag_hold: assert property (f |=> f) else $error("hold");
   chk_no_stray: assert property (!(ev || f) |=> !f) else $error("s");
   chk_allow_flag: assert property (prog_erase_allow_o != f)
      else $error("allow");
   chk_rd_fixed: assert property (avs_read_i && !w |->
      (avs_readdata_o | 32'h90) == 32'h90) else $error("rd");
   chk_wait_one: assert property (w |=> !w) else $error("wait");
   chk_copy_pulse: assert property (c |=> !c) else $error("copy");
   chk_copy_cause: assert property (c |-> $past(avs_write_i && !f))
      else $error("cause");
endmodule

//--- tb_fes_top.sv
/* bench for fes_top; drives every port itself */
`timescale 1ns/100ps
module tb_fes_top import fes_pkg::*;;
   logic clk_i = '0, reset_n_i = '0, avs_read_i = '0, avs_write_i = '0;
   logic op_active_i = '0, avs_waitrequest_o, flash_fault_flag_o;
   logic prog_erase_allow_o, program_copy_request_o;
   logic [3:0] avs_address_i = '0, avs_byteenable_i = 4'h1;
   logic [31:0] avs_writedata_i = 32'hFF, avs_readdata_o;
   fes_events_t events_i = '0;
   int num_errors = 0, n_compared = 0;
   fes_top dut (.*);
   initial forever #2.5 clk_i = ~clk_i;
   task results(int bad);
      num_errors += bad;
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task acc(logic r, logic [3:0] a, logic [7:0] e);
      @(posedge clk_i);
      {avs_read_i, avs_write_i, avs_address_i} <= {r, !r, a};
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      {avs_read_i, avs_write_i} <= 2'h0;
      n_compared++;
      if (r && avs_readdata_o !== {24'h0, e}) begin
         num_errors++;
         $display("wrong value rdata %h %h", e, avs_readdata_o);
      end
      if (!r) begin
         @(posedge clk_i);
         if (program_copy_request_o !== e[0]) begin
            num_errors++;
            $display("wrong value copy %h %h", e[0], program_copy_request_o);
         end
      end
   endtask
   initial begin
      for (int i = 0; i < 6; i++) begin
         reset_n_i <= 1'b0;
         repeat ((i > 0 && !i[0]) ? FES_HOLD_CYC : 3) @(posedge clk_i);
         reset_n_i <= 1'b1;
         {op_active_i, events_i} <= {i[0], 3'h1 << i[2:1]};
         @(posedge clk_i);
         {op_active_i, events_i} <= 4'h0;
         acc(1, 4'hF, 8'h0);
         acc(0, 4'h0, {7'h0, !i[0]});
         acc(1, 4'h0, {3'h4, i[0], 4'h0});
         n_compared++;
         if ({flash_fault_flag_o, prog_erase_allow_o}
               !== {i[0], !i[0]}) begin
            num_errors++;
            $display("wrong value flag %b %b", i[0], flash_fault_flag_o);
         end
      end
      results(0);
   end
   initial #400000 results(1);
endmodule
bind fes_top fes_properties chk (.*);
